// ### inc/ssd_pkg.sv
// constants, encodings and types for the service switch command decoder
// assumes a free-running 10 MHz clock; switch positions arrive as 1..16
package ssd_pkg;

  // clock and timebase
  localparam int CLK_HZ          = 10_000_000;
  localparam int SEC_CYCLES      = CLK_HZ * 1;

  // times in seconds and minutes, as specified
  localparam logic [3:0]  HOLD_SHORT_S = 4'h2;
  localparam logic [3:0]  HOLD_LONG_S  = 4'hA;
  localparam logic [2:0]  SHOW_S       = 3'h5;
  localparam int          TEST_MIN     = 60;
  localparam logic [11:0] TEST_TICKS   = 12'(TEST_MIN * 60 + 1);

  // selector positions
  localparam logic [4:0] POS_REST      = 5'h01;
  localparam logic [4:0] GRP_SERVICE   = 5'h02;
  localparam logic [4:0] GRP_INDIV     = 5'h10;
  localparam logic [4:0] SUB_SERVICE   = 5'h01;
  localparam logic [4:0] ITEM_COOL     = 5'h05;
  localparam logic [4:0] ITEM_HEAT     = 5'h06;
  localparam logic [4:0] ITEM_BATCH    = 5'h07;
  localparam logic [4:0] POS_MAX       = 5'h10;
  localparam logic [4:0] SUB_ADDR_MAX  = 5'h04;

  // commands toward the indoor units
  localparam logic [2:0] CMD_NONE      = 3'h0;
  localparam logic [2:0] CMD_COOL_TEST = 3'h1;
  localparam logic [2:0] CMD_HEAT_TEST = 3'h2;
  localparam logic [2:0] CMD_START     = 3'h3;
  localparam logic [2:0] CMD_STOP      = 3'h4;
  localparam logic [2:0] CMD_TEST      = 3'h5;
  localparam logic [2:0] CMD_NORMAL    = 3'h6;
  localparam logic [6:0] ADDR_ALL      = 7'h00;

  // two-character display texts, ascii high character first
  localparam logic [15:0] TXT_C     = 16'h4320;
  localparam logic [15:0] TXT_MC    = 16'h2D43;
  localparam logic [15:0] TXT_H     = 16'h4820;
  localparam logic [15:0] TXT_MH    = 16'h2D48;
  localparam logic [15:0] TXT_CH    = 16'h4348;
  localparam logic [15:0] TXT_ON    = 16'h3131;
  localparam logic [15:0] TXT_OFF   = 16'h3030;
  localparam logic [15:0] TXT_FF    = 16'h4646;
  localparam logic [15:0] TXT_BLANK = 16'h2020;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h1,
    ST_SHOWN = 2'h2
  } ssd_state_t;

endpackage

// ### rtl/ssd_decoder.sv
// service switch decoder: selectors and two buttons into indoor commands
// assumes switch and button pins are asynchronous, halt flag is on clk
// Summary of operation
// - on-button 2 s at 2/5/1: cooling test to all, show C / -C
// - on-button 2 s at 2/6/1: heating test to all, show H / -H
// - on-button 2 s at 2/7/1: batch start, show CH / 11 for 5 s
// - off-button 2 s at 2/7/1: batch stop, show CH / 00 for 5 s
// - batch start carries only the start command, no settings
// - on-button held 2 s, released before 10 s, at 16/address: start only that indoor unit
// - off-button 2 s at 16/address: stop only that indoor unit
// - on-button 10 s at 16/address: test only that indoor unit
// - individual start shows address and 11 for 5 s
// - individual stop shows address and 00 for 5 s
// - individual test shows address and FF for 5 s
// - only command messages are sent, nothing else is done
// - each command is sent once, never repeated
// - requests are ignored while the system is halted by an error
// - the most recently started test reverts to normal after 60 minutes
`timescale 1ns/1ns
module ssd_decoder
  import ssd_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  function_group_selector,
  input  wire logic [4:0]  function_item_selector,
  input  wire logic [4:0]  function_sub_selector,
  input  wire logic        execute_on_button,
  input  wire logic        execute_off_button,
  input  wire logic        system_halted,
  output logic             cmd_valid,
  output logic [2:0]       cmd_code,
  output logic [6:0]       cmd_addr,
  output logic             disp_override,
  output logic [15:0]      disp_a,
  output logic [15:0]      disp_b
);

  localparam logic [23:0] SEC_LAST = 24'(SEC_CYC - 1);

  function automatic logic [6:0] addr_of(input logic [4:0] item,
                                         input logic [4:0] sub);
    logic [6:0] base;
    base = {1'b0, sub[1:0] - 2'h1, 4'h0};
    return base + {2'h0, item};
  endfunction

  function automatic logic [15:0] to_dec(input logic [6:0] a);
    logic [6:0] tens;
    logic [6:0] ones;
    tens = a / 7'd10;
    ones = a - 7'(tens * 7'd10);
    return {4'h3, tens[3:0], 4'h3, ones[3:0]};
  endfunction

  // two-stage synchronisers for every switch and button pin
  logic [4:0]  grp_s1_ff, grp_s2_ff, item_s1_ff, item_s2_ff;
  logic [4:0]  sub_s1_ff, sub_s2_ff;
  logic        on_s1_ff, on_s2_ff, off_s1_ff, off_s2_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      grp_s1_ff  <= POS_REST;
      grp_s2_ff  <= POS_REST;
      item_s1_ff <= POS_REST;
      item_s2_ff <= POS_REST;
      sub_s1_ff  <= POS_REST;
      sub_s2_ff  <= POS_REST;
      on_s1_ff   <= 1'b0;
      on_s2_ff   <= 1'b0;
      off_s1_ff  <= 1'b0;
      off_s2_ff  <= 1'b0;
    end else begin
      grp_s1_ff  <= function_group_selector;
      grp_s2_ff  <= grp_s1_ff;
      item_s1_ff <= function_item_selector;
      item_s2_ff <= item_s1_ff;
      sub_s1_ff  <= function_sub_selector;
      sub_s2_ff  <= sub_s1_ff;
      on_s1_ff   <= execute_on_button;
      on_s2_ff   <= on_s1_ff;
      off_s1_ff  <= execute_off_button;
      off_s2_ff  <= off_s1_ff;
    end
  end

  // selector decode
  wire logic       svc     = grp_s2_ff == GRP_SERVICE &&
                             sub_s2_ff == SUB_SERVICE;
  wire logic       indiv   = grp_s2_ff == GRP_INDIV &&
                             sub_s2_ff >= POS_REST &&
                             sub_s2_ff <= SUB_ADDR_MAX &&
                             item_s2_ff >= POS_REST &&
                             item_s2_ff <= POS_MAX;
  wire logic [6:0] sel_addr = addr_of(item_s2_ff, sub_s2_ff);
  wire logic       at_rest = grp_s2_ff == POS_REST &&
                             item_s2_ff == POS_REST &&
                             sub_s2_ff == POS_REST;

  // continuous hold measurement, one button at a time
  logic        prev_on_ff, prev_off_ff;
  logic [23:0] hold_cyc_ff;
  logic [3:0]  hold_sec_ff;

  wire logic on_now   = on_s2_ff & ~off_s2_ff;
  wire logic off_now  = off_s2_ff & ~on_s2_ff;
  wire logic pressed  = on_now | off_now;
  wire logic same     = on_now == prev_on_ff && off_now == prev_off_ff;
  wire logic sec_step = pressed && same && hold_cyc_ff == SEC_LAST;
  wire logic reach_short = sec_step && hold_sec_ff == HOLD_SHORT_S - 4'h1;
  wire logic reach_long  = sec_step && hold_sec_ff == HOLD_LONG_S - 4'h1;
  wire logic on_release  = prev_on_ff && !on_now &&
                           hold_sec_ff >= HOLD_SHORT_S &&
                           hold_sec_ff < HOLD_LONG_S;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_on_ff  <= 1'b0;
      prev_off_ff <= 1'b0;
      hold_cyc_ff <= 24'h00_0000;
      hold_sec_ff <= 4'h0;
    end else begin
      prev_on_ff  <= on_now;
      prev_off_ff <= off_now;
      if (!pressed || !same) begin
        hold_cyc_ff <= 24'h00_0000;
        hold_sec_ff <= 4'h0;
      end else if (sec_step) begin
        hold_cyc_ff <= 24'h00_0000;
        if (hold_sec_ff != HOLD_LONG_S)
          hold_sec_ff <= hold_sec_ff + 4'h1;
      end else begin
        hold_cyc_ff <= hold_cyc_ff + 24'h00_0001;
      end
    end
  end

  // request recognition, blocked while halted
  wire logic ok        = !system_halted;
  wire logic f_cool    = ok && svc && item_s2_ff == ITEM_COOL &&
                         on_now && reach_short;
  wire logic f_heat    = ok && svc && item_s2_ff == ITEM_HEAT &&
                         on_now && reach_short;
  wire logic f_bstart  = ok && svc && item_s2_ff == ITEM_BATCH &&
                         on_now && reach_short;
  wire logic f_bstop   = ok && svc && item_s2_ff == ITEM_BATCH &&
                         off_now && reach_short;
  wire logic f_istart  = ok && indiv && on_release;
  wire logic f_istop   = ok && indiv && off_now && reach_short;
  wire logic f_itest   = ok && indiv && on_now && reach_long;
  wire logic user_fire = f_cool | f_heat | f_bstart | f_bstop |
                         f_istart | f_istop | f_itest;
  wire logic starts_test = f_cool | f_heat | f_itest;

  // command, address and texts of the recognised request
  wire logic [2:0]  u_code =
      f_cool   ? CMD_COOL_TEST :
      f_heat   ? CMD_HEAT_TEST :
      (f_bstart | f_istart) ? CMD_START :
      (f_bstop  | f_istop)  ? CMD_STOP  :
      f_itest  ? CMD_TEST : CMD_NONE;
  wire logic [6:0]  u_addr = indiv ? sel_addr : ADDR_ALL;
  wire logic [15:0] u_txt_a = f_cool ? TXT_C : f_heat ? TXT_H :
                              indiv ? to_dec(sel_addr) : TXT_CH;
  wire logic [15:0] u_txt_b =
      f_cool ? TXT_MC : f_heat ? TXT_MH :
      (f_bstart | f_istart) ? TXT_ON :
      (f_bstop  | f_istop)  ? TXT_OFF : TXT_FF;
  wire logic u_timed = ~(f_cool | f_heat);

  // free one-second tick for display and test timers
  logic [23:0] tick_cyc_ff;
  wire logic   tick = tick_cyc_ff == SEC_LAST;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      tick_cyc_ff <= 24'h00_0000;
    else
      tick_cyc_ff <= tick ? 24'h00_0000 : tick_cyc_ff + 24'h00_0001;
  end

  // automatic return from test operation
  logic        test_run_ff;
  logic [11:0] test_sec_ff;
  logic [6:0]  test_addr_ff;
  wire logic   revert_go = test_run_ff && test_sec_ff == TEST_TICKS &&
                           !user_fire;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_run_ff  <= 1'b0;
      test_sec_ff  <= 12'h000;
      test_addr_ff <= ADDR_ALL;
    end else if (starts_test) begin
      test_run_ff  <= 1'b1;
      test_sec_ff  <= 12'h000;
      test_addr_ff <= u_addr;
    end else if (revert_go) begin
      test_run_ff  <= 1'b0;
    end else if (test_run_ff && tick && test_sec_ff != TEST_TICKS) begin
      test_sec_ff  <= test_sec_ff + 12'h001;
    end
  end

  // command message: one pulse per accepted request, no retry
  logic       cmd_valid_ff;
  logic [2:0] cmd_code_ff;
  logic [6:0] cmd_addr_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_valid_ff <= 1'b0;
      cmd_code_ff  <= CMD_NONE;
      cmd_addr_ff  <= ADDR_ALL;
    end else begin
      cmd_valid_ff <= user_fire | revert_go;
      if (user_fire) begin
        cmd_code_ff <= u_code;
        cmd_addr_ff <= u_addr;
      end else if (revert_go) begin
        cmd_code_ff <= CMD_NORMAL;
        cmd_addr_ff <= test_addr_ff;
      end
    end
  end

  // display ownership and timed second section
  ssd_state_t  state_ff, nxt_state;
  logic [15:0] disp_a_ff, disp_b_ff;
  logic [2:0]  show_sec_ff;
  logic        show_timed_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:  if (user_fire) nxt_state = ST_SHOWN;
      ST_SHOWN: if (at_rest && !user_fire) nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff      <= ST_IDLE;
      disp_a_ff     <= TXT_BLANK;
      disp_b_ff     <= TXT_BLANK;
      show_sec_ff   <= 3'h0;
      show_timed_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (user_fire) begin
        disp_a_ff     <= u_txt_a;
        disp_b_ff     <= u_txt_b;
        show_sec_ff   <= 3'h0;
        show_timed_ff <= u_timed;
      end else if (show_timed_ff && tick) begin
        if (show_sec_ff == SHOW_S - 3'h1) begin
          disp_b_ff     <= TXT_BLANK;
          show_timed_ff <= 1'b0;
        end
        show_sec_ff <= show_sec_ff + 3'h1;
      end
    end
  end

  assign cmd_valid     = cmd_valid_ff;
  assign cmd_code      = cmd_code_ff;
  assign cmd_addr      = cmd_addr_ff;
  assign disp_override = state_ff == ST_SHOWN;
  assign disp_a        = disp_a_ff;
  assign disp_b        = disp_b_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_cool;
    f_cool |=> cmd_valid && cmd_code == CMD_COOL_TEST &&
               cmd_addr == ADDR_ALL && disp_b == TXT_MC && disp_override;
  endproperty
  a_cool: assert property (p_cool) else $error("cool test not issued");
  property p_heat;
    f_heat |=> cmd_code == CMD_HEAT_TEST && disp_a == TXT_H &&
               disp_b == TXT_MH;
  endproperty
  a_heat: assert property (p_heat) else $error("heat test not issued");
  property p_bstart;
    f_bstart |=> cmd_valid && cmd_code == CMD_START &&
                 cmd_addr == ADDR_ALL && disp_a == TXT_CH && disp_b == TXT_ON;
  endproperty
  a_bstart: assert property (p_bstart) else $error("batch start bad");
  property p_bstop;
    f_bstop |=> cmd_code == CMD_STOP && disp_b == TXT_OFF;
  endproperty
  a_bstop: assert property (p_bstop) else $error("batch stop bad");
  property p_istart;
    f_istart |=> cmd_code == CMD_START && cmd_addr == $past(sel_addr) &&
                 disp_a == to_dec($past(sel_addr));
  endproperty
  a_istart: assert property (p_istart) else $error("indiv start bad");
  property p_itest;
    f_itest |-> hold_sec_ff == HOLD_LONG_S - 4'h1 ##1
      cmd_valid && cmd_code == CMD_TEST && disp_b == TXT_FF;
  endproperty
  a_itest: assert property (p_itest) else $error("indiv test bad");

  // remembers that the current unbroken press has already sent its command
  logic fired_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      fired_ff <= 1'b0;
    else
      fired_ff <= pressed && same && (user_fire || fired_ff);
  end

  property p_once;
    fired_ff |-> !user_fire;
  endproperty
  a_once: assert property (p_once) else $error("command repeated");
  property p_halt;
    system_halted |=> !cmd_valid || cmd_code == CMD_NORMAL;
  endproperty
  a_halt: assert property (p_halt) else $error("request while halted");
  property p_rest;
    at_rest |=> !disp_override;
  endproperty
  a_rest: assert property (p_rest) else $error("release missed");
  property p_revert;
    revert_go |=> cmd_valid && cmd_code == CMD_NORMAL && !test_run_ff;
  endproperty
  a_revert: assert property (p_revert) else $error("no revert");

endmodule

// ### dv/ssd_indoor_model.sv
// indoor unit controllers as seen from the command outputs
// assumes one command message per cycle of cmd_valid, on clk
`timescale 1ns/1ns
module ssd_indoor_model
  import ssd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_code,
  input  wire logic [6:0]  cmd_addr,
  output logic      [15:0] n_cmd,
  output logic      [64:0] unit_on
);
  logic [15:0] n_cmd_ff;
  logic [64:0] unit_on_ff;
  logic [64:0] sel_mask;

  // bit 0 unused, bits 1..64 are the indoor addresses
  assign sel_mask = (cmd_addr == ADDR_ALL) ? {{64{1'b1}}, 1'b0}
                                           : (65'h1 << cmd_addr);
  assign n_cmd    = n_cmd_ff;
  assign unit_on  = unit_on_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n_cmd_ff   <= 16'h0000;
      unit_on_ff <= '0;
    end else if (cmd_valid) begin
      n_cmd_ff <= n_cmd_ff + 16'h0001;
      if (cmd_code == CMD_START) begin
        unit_on_ff <= unit_on_ff | sel_mask;
      end else if (cmd_code == CMD_STOP) begin
        unit_on_ff <= unit_on_ff & ~sel_mask;
      end
    end
  end
endmodule

// ### dv/ssd_decoder_bench.sv
// self-checking bench for the service switch command decoder
// assumes a shortened second of SC clock cycles
`timescale 1ns/1ns
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin \
  n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, s); end end
module ssd_decoder_bench;
  import ssd_pkg::*;
  localparam int SC = 4;
  logic        clk, rst_n, on_b, off_b, halt;
  logic [4:0]  grp, item, sub;
  logic        cmd_valid, disp_override;
  logic [2:0]  cmd_code;
  logic [6:0]  cmd_addr;
  logic [15:0] disp_a, disp_b, n_cmd, base;
  logic [64:0] unit_on;
  int          n_mismatch = 0;
  int          checked = 0;

  ssd_decoder #(.SEC_CYC(SC)) ssd_decoder_i (
    .clk(clk), .rst_n(rst_n), .function_group_selector(grp),
    .function_item_selector(item), .function_sub_selector(sub),
    .execute_on_button(on_b), .execute_off_button(off_b),
    .system_halted(halt), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .disp_override(disp_override),
    .disp_a(disp_a), .disp_b(disp_b));
  ssd_indoor_model ssd_indoor_model_i (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .n_cmd(n_cmd), .unit_on(unit_on));

  always #50 clk = ~clk;

  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic sel(input logic [4:0] g, input logic [4:0] i,
                     input logic [4:0] s);
    grp  <= g;
    item <= i;
    sub  <= s;
    repeat (4) @(posedge clk);
  endtask

  // hold a button for whole seconds, then release and let it settle
  task automatic push(input logic which, input int secs);
    if (which) on_b <= 1'b1;
    else off_b <= 1'b1;
    repeat (secs * SC) @(posedge clk);
    on_b  <= 1'b0;
    off_b <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic rest;
    sel(5'h01, 5'h01, 5'h01);
    `CHK("override", 1'b0, disp_override)
  endtask

  task automatic chk(input int n, input logic [2:0] c,
                     input logic [6:0] a, input logic [15:0] da,
                     input logic [15:0] db);
    base = base + 16'(n);
    `CHK("count", base, n_cmd)
    `CHK("code", c, cmd_code)
    `CHK("addr", a, cmd_addr)
    `CHK("disp_a", da, disp_a)
    `CHK("disp_b", db, disp_b)
    `CHK("override", 1'b1, disp_override)
  endtask

  initial begin
    clk = 1'b0; rst_n = 1'b0; on_b = 1'b0; off_b = 1'b0; halt = 1'b0;
    grp = 5'h01; item = 5'h01; sub = 5'h01; base = 16'h0000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("rst_disp", TXT_BLANK, disp_a)
    `CHK("rst_code", CMD_NONE, cmd_code)
    sel(GRP_SERVICE, ITEM_COOL, SUB_SERVICE);
    push(1'b1, 3);
    chk(1, CMD_COOL_TEST, ADDR_ALL, TXT_C, TXT_MC);
    rest();
    sel(GRP_SERVICE, ITEM_HEAT, SUB_SERVICE);
    push(1'b1, 3);
    chk(1, CMD_HEAT_TEST, ADDR_ALL, TXT_H, TXT_MH);
    rest();
    sel(GRP_SERVICE, ITEM_BATCH, SUB_SERVICE);
    push(1'b1, 1);
    `CHK("short", base, n_cmd)
    push(1'b1, 3);
    chk(1, CMD_START, ADDR_ALL, TXT_CH, TXT_ON);
    `CHK("units", {{64{1'b1}}, 1'b0}, unit_on)
    repeat (6 * SC) @(posedge clk);
    `CHK("blank", TXT_BLANK, disp_b)
    sel(GRP_INDIV, 5'h10, SUB_ADDR_MAX);
    push(1'b0, 3);
    chk(1, CMD_STOP, 7'h40, 16'h3634, TXT_OFF);
    `CHK("units", {1'b0, {63{1'b1}}, 1'b0}, unit_on)
    sel(GRP_SERVICE, ITEM_BATCH, SUB_SERVICE);
    push(1'b0, 3);
    chk(1, CMD_STOP, ADDR_ALL, TXT_CH, TXT_OFF);
    rest();
    halt <= 1'b1;
    sel(GRP_SERVICE, ITEM_BATCH, SUB_SERVICE);
    push(1'b1, 3);
    `CHK("halted", base, n_cmd)
    halt <= 1'b0;
    rest();
    sel(GRP_INDIV, 5'h03, 5'h02);
    push(1'b1, 3);
    chk(1, CMD_START, 7'h13, 16'h3139, TXT_ON);
    `CHK("units", 65'h1 << 19, unit_on)
    sel(GRP_INDIV, 5'h01, 5'h01);
    push(1'b1, 11);
    chk(1, CMD_TEST, 7'h01, 16'h3031, TXT_FF);
    rest();
    repeat (3599 * SC - 30) @(posedge clk);
    `CHK("early", base, n_cmd)
    for (int k = 0; k < 12 * SC && n_cmd === base; k++) @(posedge clk);
    @(posedge clk);
    `CHK("revert", base + 16'h0001, n_cmd)
    `CHK("rv_code", CMD_NORMAL, cmd_code)
    `CHK("rv_addr", 7'h01, cmd_addr)
    end_sim();
  end

  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
endmodule
